// [include/rss_pkg.sv]
// Constants and types shared by the reference switchover controller.
// Function
// RULE_01: Manual mode: bit 5 picks bit 6 or pin.
// RULE_02: Register select: bit 6 zero first, one second.
// RULE_03: Bit 4: zero manual, one automatic switchover.
// RULE_04: Software keeps single-ended mode under automatic switchover.
// RULE_05: Automatic mode powers both inputs, ignoring bits 2:1.
// RULE_06: Bit 3 zero reverts to first; one stays.
// RULE_07: Bit 2 powers second input unless automatic.
// RULE_08: Bit 1 powers first input unless automatic.
// RULE_09: Bit 0 selects differential or single-ended reference.
// RULE_10: Software clears bits 2:1 when differential set.
// RULE_11: Selection re-evaluated whenever any control input changes.
package rss_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] RSS_CTRL_OFF = 12'h01C;
  localparam logic [11:0] RSS_STAT_OFF = 12'h020;
  localparam logic [11:0] RSS_COUNT_OFF = 12'h024;
  localparam logic [7:0] RSS_CTRL_RESET = 8'h00;
  localparam int RSS_CTRL_W = 8;
  localparam int RSS_COUNT_W = 16;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int RSS_B_DIFF = 0;
  localparam int RSS_B_FIRST_PWR = 1;
  localparam int RSS_B_SECOND_PWR = 2;
  localparam int RSS_B_STAY = 3;
  localparam int RSS_B_AUTO = 4;
  localparam int RSS_B_USE_PIN = 5;
  localparam int RSS_B_SEL_SECOND = 6;
  localparam int RSS_B_DEGLITCH_OFF = 7;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int RSS_S_ACTIVE_SECOND = 0;
  localparam int RSS_S_FIRST_PWR = 1;
  localparam int RSS_S_SECOND_PWR = 2;
  localparam int RSS_S_SWITCHED = 3;
  localparam int RSS_S_FIRST_GOOD = 4;
  localparam int RSS_S_SECOND_GOOD = 5;

  typedef enum logic [0:0] {
    RSS_ON_FIRST = 1'b0,
    RSS_ON_SECOND = 1'b1
  } rss_state_t;

endpackage

// [include/rss_sel_if.sv]
// Carrier between the register block and the reference selector.
`timescale 1ns/1ps
interface rss_sel_if;
  logic autoEn;
  logic usePin;
  logic manualSecond;
  logic staySecond;
  logic refSelPin;
  logic firstGood;
  logic secondGood;
  logic activeSecond;
  logic switchPulse;

  modport ctrl (
    output autoEn, usePin, manualSecond, staySecond, refSelPin, firstGood, secondGood,
    input activeSecond, switchPulse
  );
  modport sel (
    input autoEn, usePin, manualSecond, staySecond, refSelPin, firstGood, secondGood,
    output activeSecond, switchPulse
  );
endinterface

// [rtl/rss_ref_select.sv]
// Reference selector: manual choice or automatic switchover state machine.
`timescale 1ns/1ps
module rss_ref_select
  import rss_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  rss_sel_if.sel sel
);

  rss_state_t state_reg;
  rss_state_t state_next;
  logic manualChoice;

  // The manual source only matters while automatic mode is off.
  assign manualChoice = sel.usePin ? sel.refSelPin : sel.manualSecond; // see RULE_01, RULE_02

  // Evaluated every cycle, so any control or pin change is seen at once.
  always_comb begin // see RULE_11
    state_next = state_reg;
    if (!sel.autoEn) begin // see RULE_03
      state_next = manualChoice ? RSS_ON_SECOND : RSS_ON_FIRST;
    end else begin
      case (state_reg)
        RSS_ON_FIRST: begin
          if (!sel.firstGood && sel.secondGood) begin
            state_next = RSS_ON_SECOND;
          end
        end
        RSS_ON_SECOND: begin
          if (!sel.staySecond && sel.firstGood) begin // see RULE_06
            state_next = RSS_ON_FIRST;
          end
        end
        default: state_next = RSS_ON_FIRST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= RSS_ON_FIRST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Only automatic moves count as switchover events.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel.switchPulse <= 1'b0;
    end else begin
      sel.switchPulse <= sel.autoEn && (state_next != state_reg);
    end
  end

  assign sel.activeSecond = (state_reg == RSS_ON_SECOND);

endmodule

// [rtl/rss_switchover_ctrl.sv]
// Reference switchover controller with APB register access.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module rss_switchover_ctrl
  import rss_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic refSelPin,
  input wire logic firstRefGood,
  input wire logic secondRefGood,
  output logic selectSecondRef,
  output logic firstRefPowerEn,
  output logic secondRefPowerEn,
  output logic diffRefMode,
  output logic deglitchDisable
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < 6 || ADDR_W > 12) begin : gChk
    $error("ADDR_W must lie between 6 and 12");
  end

  // Every control field sits in byte lane zero, and the counter must fit one read word.
  if (RSS_CTRL_W != 8) begin : gChkCtrl
    $error("control register must fill exactly the lowest byte lane");
  end

  if (RSS_COUNT_W < 1 || RSS_COUNT_W > 32) begin : gChkCount
    $error("switch counter must fit one bus word");
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic [RSS_CTRL_W-1:0] ctrl_reg;
  logic switched_reg;
  logic [RSS_COUNT_W-1:0] count_reg;
  logic access;
  logic wrEn;
  logic hitCtrl;
  logic hitStat;
  logic hitCount;
  logic mapped;
  logic [31:0] statWord;
  logic wrCtrl;
  logic clrSwitched;
  logic clrCount;
  logic rdSetup;
  logic [31:0] rdWord;

  function automatic logic addrHit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    addrHit = (12'(a) == off);
  endfunction

  assign access = psel && penable;
  assign hitCtrl = addrHit(paddr, RSS_CTRL_OFF);
  assign hitStat = addrHit(paddr, RSS_STAT_OFF);
  assign hitCount = addrHit(paddr, RSS_COUNT_OFF);
  assign mapped = hitCtrl || hitStat || hitCount;
  assign wrEn = access && pwrite && mapped;
  // Byte lane zero carries every field, so the other strobes have no effect.
  assign wrCtrl = wrEn && hitCtrl && pstrb[0];
  assign clrSwitched = wrEn && hitStat && pstrb[0] && pwdata[RSS_S_SWITCHED];
  // Any write clears the counter, whatever the data, except in a cycle with a switchover pulse; no read-modify-write is needed.
  assign clrCount = wrEn && hitCount;
  assign rdSetup = psel && !penable && !pwrite;

  // ---------------------------------------------------------------
  // Bus response
  // ---------------------------------------------------------------
  // Zero wait states keep the slave simple; every access ends in its first cycle.
  assign pready = 1'b1;
  // An unmapped offset answers with an error, so a wrong address in software is
  // caught instead of quietly reading as zero.
  assign pslverr = access && !mapped;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= RSS_CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_reg <= pwdata[RSS_CTRL_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Selector
  // ---------------------------------------------------------------
  // The selector gets only the fields that steer it; power and mode bits stay here,
  // as they do not depend on which reference is active.
  rss_sel_if selBus ();

  assign selBus.autoEn = ctrl_reg[RSS_B_AUTO];
  assign selBus.usePin = ctrl_reg[RSS_B_USE_PIN];
  assign selBus.manualSecond = ctrl_reg[RSS_B_SEL_SECOND];
  assign selBus.staySecond = ctrl_reg[RSS_B_STAY];
  assign selBus.refSelPin = refSelPin;
  assign selBus.firstGood = firstRefGood;
  assign selBus.secondGood = secondRefGood;

  rss_ref_select uSel (
    .clk(clk),
    .arst_n(arst_n),
    .sel(selBus.sel)
  );

  assign selectSecondRef = selBus.activeSecond;

  // ---------------------------------------------------------------
  // Power and mode outputs
  // ---------------------------------------------------------------
  // Automatic mode may fall back to either input at any moment, so both stay powered.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      firstRefPowerEn <= 1'b0;
    end else begin
      firstRefPowerEn <= ctrl_reg[RSS_B_AUTO] | ctrl_reg[RSS_B_FIRST_PWR]; // see RULE_05, RULE_08
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      secondRefPowerEn <= 1'b0;
    end else begin
      secondRefPowerEn <= ctrl_reg[RSS_B_AUTO] | ctrl_reg[RSS_B_SECOND_PWR]; // see RULE_05, RULE_07
    end
  end

  // Differential mode with automatic switchover is the software's mistake to avoid;
  // the hardware passes both bits through unchanged rather than guessing. (see RULE_04)
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      diffRefMode <= 1'b0;
    end else begin
      diffRefMode <= ctrl_reg[RSS_B_DIFF]; // see RULE_09
    end
  end

  // Stored and driven only; the deglitch circuit itself lives outside this block.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      deglitchDisable <= 1'b0;
    end else begin
      deglitchDisable <= ctrl_reg[RSS_B_DEGLITCH_OFF];
    end
  end

  // ---------------------------------------------------------------
  // Switchover history
  // ---------------------------------------------------------------
  // A switchover in the cycle of a clearing write keeps the flag set.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      switched_reg <= 1'b0;
    end else if (selBus.switchPulse) begin
      switched_reg <= 1'b1;
    end else if (clrSwitched) begin
      switched_reg <= 1'b0;
    end
  end

  // The counter saturates so a flapping reference cannot wrap it back to a small value.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
    end else if (selBus.switchPulse && !(&count_reg)) begin
      count_reg <= count_reg + RSS_COUNT_W'(1);
    end else if (!selBus.switchPulse && clrCount) begin
      count_reg <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Status shows the live monitor inputs, so software sees a recovery as soon as the
  // monitor reports it.
  always_comb begin
    statWord = '0;
    statWord[RSS_S_ACTIVE_SECOND] = selBus.activeSecond;
    statWord[RSS_S_FIRST_PWR] = firstRefPowerEn;
    statWord[RSS_S_SECOND_PWR] = secondRefPowerEn;
    statWord[RSS_S_SWITCHED] = switched_reg;
    statWord[RSS_S_FIRST_GOOD] = firstRefGood;
    statWord[RSS_S_SECOND_GOOD] = secondRefGood;
  end

  // The word is picked in the setup cycle and stands in prdata for the whole access
  // phase; the extra flops keep the live status inputs off a path to the bus pins.
  always_comb begin
    rdWord = '0;
    if (hitCtrl) begin
      rdWord = 32'(ctrl_reg);
    end else if (hitStat) begin
      rdWord = statWord;
    end else if (hitCount) begin
      rdWord = 32'(count_reg);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
    end else if (rdSetup) begin
      prdata <= rdWord;
    end
  end

endmodule

// [tb/rss_switchover_ctrl_sva.sv]
// Concurrent checks on the switchover controller ports.
`timescale 1ns/1ps
module rss_switchover_ctrl_sva
  import rss_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic refSelPin,
  input wire logic firstRefGood,
  input wire logic secondRefGood,
  input wire logic selectSecondRef,
  input wire logic firstRefPowerEn,
  input wire logic secondRefPowerEn,
  input wire logic diffRefMode,
  input wire logic deglitchDisable
);
  // Shadow of the control word, rebuilt from accepted writes.
  logic [7:0] c;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c <= 8'h00;
    end else if (psel && penable && pwrite && pstrb[0] && paddr == RSS_CTRL_OFF) begin
      c <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_PIN_SEL: assert property (!c[4] && c[5] |=> selectSecondRef == $past(refSelPin))
    else $error("pin select not followed");
  AST_REG_SEL: assert property (!c[4] && !c[5] |=> selectSecondRef == $past(c[6]))
    else $error("register select not followed");
  AST_AUTO_PWR: assert property (c[4] |=> firstRefPowerEn && secondRefPowerEn)
    else $error("auto mode power off");
  AST_PWR_SECOND: assert property (!c[4] |=> secondRefPowerEn == $past(c[2]))
    else $error("second power wrong");
  AST_PWR_FIRST: assert property (!c[4] |=> firstRefPowerEn == $past(c[1]))
    else $error("first power wrong");
  AST_DIFF: assert property (diffRefMode == $past(c[0]) || $rose(arst_n))
    else $error("diff mode wrong");
  AST_DEGLITCH: assert property (deglitchDisable == $past(c[7]))
    else $error("deglitch disable wrong");
  AST_GO_SECOND: assert property (c[4] && !selectSecondRef && !firstRefGood && secondRefGood
    |=> selectSecondRef)
    else $error("no switch to second");
  AST_REVERT: assert property (c[4] && !c[3] && selectSecondRef && firstRefGood
    |=> !selectSecondRef)
    else $error("no revert");
  AST_STAY: assert property (c[4] && c[3] && selectSecondRef |=> selectSecondRef)
    else $error("left second");
  COV_GO: cover property (c[4] && $rose(selectSecondRef));
  COV_REVERT: cover property (c[4] && !c[3] && $fell(selectSecondRef));
  COV_PIN: cover property (!c[4] && c[5] && refSelPin);
endmodule
bind rss_switchover_ctrl rss_switchover_ctrl_sva #(.ADDR_W(ADDR_W)) chk (
  .clk(clk),
  .arst_n(arst_n),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .refSelPin(refSelPin),
  .firstRefGood(firstRefGood),
  .secondRefGood(secondRefGood),
  .selectSecondRef(selectSecondRef),
  .firstRefPowerEn(firstRefPowerEn),
  .secondRefPowerEn(secondRefPowerEn),
  .diffRefMode(diffRefMode),
  .deglitchDisable(deglitchDisable)
);

// [tb/rss_board_model.sv]
// Board-side model: external select pin and reference monitor status.
`timescale 1ns/1ps
module rss_board_model (
  input wire logic clk,
  input wire logic [2:0] want,
  output logic refSelPin = 1'b0,
  output logic firstRefGood = 1'b0,
  output logic secondRefGood = 1'b0
);
  // Levels move just after an edge, as a synchronous board source would.
  always @(posedge clk) begin
    {secondRefGood, firstRefGood, refSelPin} <= want;
  end
endmodule

// [tb/test_rss_switchover_ctrl.sv]
// Self-checking bench for the reference switchover controller.
`timescale 1ns/1ps
module test_rss_switchover_ctrl
  import rss_pkg::*;
;
  localparam logic [32:0] MA = 33'h1FFFFFFFF;
  localparam logic [32:0] MS = 33'h100000037;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000FFBD;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] want = 3'h0;
  logic refSelPin, firstRefGood, secondRefGood;
  logic selectSecondRef, firstRefPowerEn, secondRefPowerEn, diffRefMode;
  logic [32:0] expQ[$], mskQ[$];
  logic [3:0] au [5] = '{4'h6, 4'h3, 4'h6, 4'hB, 4'hF};
  logic [7:0] v;
  int n_mismatch = 0, n_compared = 0;
  always #2 clk = ~clk;
  rss_switchover_ctrl uut (
    .clk(clk),
    .arst_n(arst_n),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .refSelPin(refSelPin),
    .firstRefGood(firstRefGood),
    .secondRefGood(secondRefGood),
    .selectSecondRef(selectSecondRef),
    .firstRefPowerEn(firstRefPowerEn),
    .secondRefPowerEn(secondRefPowerEn),
    .diffRefMode(diffRefMode),
    .deglitchDisable()
  );
  rss_board_model brd (
    .clk(clk),
    .want(want),
    .refSelPin(refSelPin),
    .firstRefGood(firstRefGood),
    .secondRefGood(secondRefGood)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [32:0] st(input logic a, p1, p2, g1, g2);
    return {27'h0, g2, g1, 1'b0, p2, p1, a};
  endfunction
  task automatic cmp(input logic [32:0] e, input logic [32:0] m);
    n_compared++;
    if (({pslverr, prdata} & m) !== (e & m)) begin
      n_mismatch++;
      $display("mismatch read expected %h seen %h", e & m, {pslverr, prdata} & m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e, input logic [32:0] m);
    if (!w) begin
      expQ.push_back(e);
      mskQ.push_back(m);
    end
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Read results are taken at the access edge, where prdata and pslverr stand.
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      cmp(expQ.pop_front(), mskQ.pop_front());
    end
  end
  initial begin
    #40000;
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apb(0, RSS_CTRL_OFF, 0, 33'h0, MA);
    apb(0, RSS_STAT_OFF, 0, st(0, 0, 0, 0, 0), MS);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      v = seed[7:0] & 8'hEF;
      if (v[0]) v = v & 8'hF9;
      want <= seed[10:8];
      apb(1, RSS_CTRL_OFF, {24'h0, v}, 0, 0);
      repeat (2) @(posedge clk);
      apb(0, RSS_CTRL_OFF, 0, {25'h0, v}, MA);
      apb(0, RSS_STAT_OFF, 0, st(v[5] ? seed[8] : v[6], v[1], v[2], seed[9], seed[10]),
        MS);
    end
    apb(1, 12'h040, 32'hFF, 0, 0);
    apb(0, 12'h040, 0, {1'b1, 32'h0}, MA);
    apb(1, RSS_CTRL_OFF, 32'h0, 0, 0);
    foreach (au[i]) begin
      want <= {au[i][1], au[i][2], 1'b0};
      apb(1, RSS_CTRL_OFF, {27'h0, 1'b1, au[i][3], 3'h0}, 0, 0);
      repeat (2) @(posedge clk);
      apb(0, RSS_STAT_OFF, 0, st(au[i][0], 1, 1, au[i][2], au[i][1]),
        MS);
    end
    apb(0, RSS_COUNT_OFF, 0, 33'h3, 33'h10000FFFF);
    apb(0, RSS_STAT_OFF, 0, 33'h3F, MA);
    apb(1, RSS_STAT_OFF, 32'h8, 0, 0);
    apb(0, RSS_STAT_OFF, 0, 33'h37, MA);
    pstrb <= 4'hE;
    apb(1, RSS_CTRL_OFF, 32'hFF, 0, 0);
    pstrb <= 4'hF;
    apb(0, RSS_CTRL_OFF, 0, 33'h18, MA);
    apb(1, RSS_COUNT_OFF, 32'h0, 0, 0);
    apb(0, RSS_COUNT_OFF, 0, 33'h0, MA);
    test_done();
  end
endmodule
